// >>> rtl/critical_msi_attr_and_affinity.v
// critical error interrupt attribute word, target/payload words, affinity and msi issue
`default_nettype none
`include "crit_msi_map.vh"

module critical_msi_attr_and_affinity #(
  parameter       HAS_IRQ_CFG    = 1,
  parameter       HAS_CRIT_IRQ   = 1,
  parameter       RECOMMENDED    = 1,
  parameter       CAN_DISABLE    = 1,
  parameter       CAN_SPACE      = 1,
  parameter       CAN_SHARE      = 1,
  parameter       CAN_MEMTYPE    = 1,
  parameter       HAS_AFFINITY   = 1,
  parameter       HAS_V11        = 1,
  parameter [0:0] SPACE_RESET    = 1'h0,
  parameter [0:0] SPACE_FIXED    = 1'h0,
  parameter [1:0] SHARE_FIXED    = 2'h2,
  parameter [3:0] MEMTYPE_FIXED  = 4'h0,
  parameter [7:0] ODD_RESET      = 8'h00
) (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire [11:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [1:0]  acc_space_i,
  output reg  [31:0] rdata_o,
  input  wire [63:0] pe_affinity_identifier_i,
  input  wire        aff_subset_i,
  input  wire [1:0]  aff_subset_level_i,
  input  wire        fw_configured_i,
  input  wire        crit_event_i,
  output reg         msi_valid_o,
  output reg  [55:0] msi_addr_o,
  output reg  [31:0] msi_data_o,
  output reg         msi_ns_o,
  output reg  [1:0]  msi_share_domain_o,
  output reg  [3:0]  msi_memory_type_o
);

  // ------------------------------------------------------------
  // presence and access classes
  // ------------------------------------------------------------
  localparam [1:0] ACC_SECURE = 2'h0;
  localparam [1:0] ACC_NONSEC = 2'h1;
  localparam [1:0] ACC_REALM  = 2'h2;

  localparam PRESENT = (HAS_IRQ_CFG != 0) && ((HAS_CRIT_IRQ != 0) || (RECOMMENDED == 0));
  localparam ODD     = (RECOMMENDED == 0);

  reg         msi_gen_on_reg;
  reg         msi_space_select_reg;
  reg  [1:0]  msi_share_domain_reg;
  reg  [3:0]  msi_memory_type_reg;
  reg  [7:0]  odd_word_reg;
  reg  [53:0] target_reg;
  reg  [31:0] payload_reg;
  reg         aff_cfg_reg;

  wire untrusted = (acc_space_i == ACC_NONSEC) || (acc_space_i == ACC_REALM);
  // one lock covers target, payload and attribute words
  wire locked    = untrusted && !ODD && !msi_space_select_reg;

  // ------------------------------------------------------------
  // effective field views
  // ------------------------------------------------------------
  wire       gen_on_view  = (CAN_DISABLE != 0) ? msi_gen_on_reg : 1'b0;
  wire       space_view   = (CAN_SPACE != 0) ? msi_space_select_reg : 1'b0;
  wire [1:0] share_view   = (CAN_SHARE != 0) ? msi_share_domain_reg : 2'h0;
  wire [3:0] memtype_view = (CAN_MEMTYPE != 0) ? msi_memory_type_reg : 4'h0;

  wire [31:0] attr_view = !PRESENT ? 32'h0 :
                          ODD ? {24'h0, odd_word_reg} :
                          {24'h0, gen_on_view, space_view, share_view, memtype_view};

  // ------------------------------------------------------------
  // affinity view
  // ------------------------------------------------------------
  reg [63:0] aff_view;
  always @* begin
    aff_view = 64'h0;
    if (HAS_AFFINITY != 0 && aff_cfg_reg && fw_configured_i) begin
      if (!aff_subset_i) begin
        aff_view       = pe_affinity_identifier_i;
        aff_view[63:40] = 24'h0;
        aff_view[31]   = 1'b1;
      end else begin
        aff_view[39:32] = pe_affinity_identifier_i[39:32];
        aff_view[23:16] = pe_affinity_identifier_i[23:16];
        aff_view[15:8]  = pe_affinity_identifier_i[15:8];
        aff_view[7:0]   = 8'h0;
        aff_view[31]    = 1'b0;
        case (aff_subset_level_i)
          2'h1: begin
            aff_view[15:8] = (HAS_V11 != 0) ? pe_affinity_identifier_i[15:8] : 8'h0;
          end
          2'h2: begin
            aff_view[15:8]  = 8'h0;
            aff_view[23:16] = (HAS_V11 != 0) ? pe_affinity_identifier_i[23:16] : 8'h0;
          end
          default: begin
            aff_view[15:8]  = 8'h0;
            aff_view[23:16] = `LEVEL_ONE_MARK;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  wire wr_attr = wr_i && PRESENT && (addr_i == `OFS_ATTRIBUTE) && !locked;
  wire wr_cfg  = wr_i && PRESENT && !locked;

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      msi_gen_on_reg       <= `RST_GEN_ON;
      msi_space_select_reg <= SPACE_RESET;
      msi_share_domain_reg <= `SH_NONE;
      msi_memory_type_reg  <= 4'h0;
      odd_word_reg         <= ODD_RESET;
      target_reg           <= 54'h0;
      payload_reg          <= 32'h0;
      aff_cfg_reg          <= 1'b0;
    end else begin
      if (wr_attr) begin
        if (ODD) begin
          odd_word_reg <= wdata_i[7:0];
        end else begin
          if (CAN_DISABLE != 0)
            msi_gen_on_reg <= wdata_i[`BIT_GEN_ON];
          if (CAN_SPACE != 0 && !untrusted)
            msi_space_select_reg <= wdata_i[`BIT_SPACE_SEL];
          if (CAN_SHARE != 0)
            msi_share_domain_reg <= wdata_i[`FLD_SHARE_HI:`FLD_SHARE_LO];
          if (CAN_MEMTYPE != 0)
            msi_memory_type_reg <= wdata_i[`FLD_MEMTYPE_HI:`FLD_MEMTYPE_LO];
        end
      end
      if (wr_cfg && addr_i == `OFS_TARGET_LO)
        target_reg[29:0] <= wdata_i[31:2];
      if (wr_cfg && addr_i == `OFS_TARGET_HI)
        target_reg[53:30] <= wdata_i[23:0];
      if (wr_cfg && addr_i == `OFS_PAYLOAD)
        payload_reg <= wdata_i;
      if (wr_i && addr_i == `OFS_AFF_CFG && !untrusted)
        aff_cfg_reg <= wdata_i[0];
    end
  end

  // ------------------------------------------------------------
  // read port: data stands one cycle after the strobe
  // ------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (addr_i)
      `OFS_ATTRIBUTE: rd_mux = attr_view;
      `OFS_TARGET_LO: rd_mux = PRESENT ? {target_reg[29:0], 2'h0} : 32'h0;
      `OFS_TARGET_HI: rd_mux = PRESENT ? {8'h0, target_reg[53:30]} : 32'h0;
      `OFS_PAYLOAD:   rd_mux = PRESENT ? payload_reg : 32'h0;
      `OFS_AFF_LO:    rd_mux = aff_view[31:0];
      `OFS_AFF_HI:    rd_mux = aff_view[63:32];
      `OFS_AFF_CFG:   rd_mux = {31'h0, aff_cfg_reg};
      default:        rd_mux = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // effective msi attributes
  // ------------------------------------------------------------
  wire       space_eff   = (CAN_SPACE != 0) ? msi_space_select_reg : SPACE_FIXED;
  wire [3:0] memtype_eff = (CAN_MEMTYPE != 0) ? msi_memory_type_reg : MEMTYPE_FIXED;
  wire       dev_or_nc   = (memtype_eff[3:2] == 2'h0) || (memtype_eff == `MT_NORMAL_NC);
  wire [1:0] share_eff   = dev_or_nc ? `SH_OUTER :
                           (CAN_SHARE != 0) ? msi_share_domain_reg : SHARE_FIXED;
  wire       may_issue   = (CAN_DISABLE != 0) ? msi_gen_on_reg : 1'b1;

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_o            <= 32'h0;
      msi_valid_o        <= 1'b0;
      msi_addr_o         <= 56'h0;
      msi_data_o         <= 32'h0;
      msi_ns_o           <= 1'b0;
      msi_share_domain_o <= 2'h0;
      msi_memory_type_o  <= 4'h0;
    end else begin
      rdata_o     <= rd_i ? rd_mux : 32'h0;
      msi_valid_o <= crit_event_i && may_issue && PRESENT;
      // attributes only move with an issued write, so they stand until the next one
      if (crit_event_i && may_issue && PRESENT) begin
        msi_addr_o         <= {target_reg, 2'h0};
        msi_data_o         <= payload_reg;
        msi_ns_o           <= space_eff;
        msi_share_domain_o <= share_eff;
        msi_memory_type_o  <= memtype_eff;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/crit_msi_map.vh
// offsets, field positions, reset values and attribute codes of the critical msi block
`ifndef CRIT_MSI_MAP_VH
`define CRIT_MSI_MAP_VH
`define OFS_TARGET_LO     12'hea0
`define OFS_TARGET_HI     12'hea4
`define OFS_PAYLOAD       12'hea8
`define OFS_ATTRIBUTE     12'heac
`define OFS_AFF_LO        12'hfa8
`define OFS_AFF_HI        12'hfac
`define OFS_AFF_CFG       12'hf00
`define BIT_GEN_ON        7
`define BIT_SPACE_SEL     6
`define FLD_SHARE_HI      5
`define FLD_SHARE_LO      4
`define FLD_MEMTYPE_HI    3
`define FLD_MEMTYPE_LO    0
`define RST_GEN_ON        1'h0
`define SH_NONE           2'h0
`define SH_OUTER          2'h2
`define SH_INNER          2'h3
`define MT_NORMAL_NC      4'h5
`define LEVEL_ONE_MARK    8'h80
`endif

// >>> testbench/crit_msi_monitor.sv
// port checker for the critical msi attribute and affinity block
`default_nettype none
module crit_msi_monitor (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic        rd_i,
  input wire logic        crit_event_i,
  input wire logic        fw_configured_i,
  input wire logic [31:0] rdata_o,
  input wire logic        msi_valid_o,
  input wire logic [55:0] msi_addr_o,
  input wire logic [31:0] msi_data_o,
  input wire logic [1:0]  msi_share_domain_o,
  input wire logic [3:0]  msi_memory_type_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_msi_cause: assert property (msi_valid_o |-> $past(crit_event_i))
    else $error("msi write without event");
  a_addr_align: assert property (msi_valid_o |-> msi_addr_o[1:0] == 2'h0)
    else $error("msi address low bits set");
  a_share_forced: assert property (msi_valid_o && (msi_memory_type_o[3:2] == 2'h0 ||
    msi_memory_type_o == 4'h5) |-> msi_share_domain_o == 2'h2) else $error("share not outer");
  a_rsvd_zero: assert property ($past(rd_i && addr_i == 12'heac) |-> rdata_o[31:8] == 24'h0)
    else $error("reserved bits read nonzero");
  a_aff_unconf: assert property ($past(rd_i && addr_i == 12'hfa8 && !fw_configured_i)
    |-> rdata_o == 32'h0) else $error("affinity nonzero before config");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !msi_valid_o && rdata_o == 32'h0)
    else $error("outputs active after reset");
  a_msi_hold: assert property (!msi_valid_o |-> $stable(msi_data_o) && $stable(msi_addr_o))
    else $error("msi fields moved without issue");
  c_msi: cover property (msi_valid_o);
  c_back: cover property (msi_valid_o ##1 msi_valid_o);
  c_aff: cover property ($past(rd_i && addr_i == 12'hfa8) && rdata_o[31]);
endmodule
bind critical_msi_attr_and_affinity crit_msi_monitor u_mon (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i), .crit_event_i(crit_event_i),
  .fw_configured_i(fw_configured_i), .rdata_o(rdata_o), .msi_valid_o(msi_valid_o),
  .msi_addr_o(msi_addr_o), .msi_data_o(msi_data_o),
  .msi_share_domain_o(msi_share_domain_o), .msi_memory_type_o(msi_memory_type_o));
`default_nettype wire

// >>> testbench/msi_sink.sv
// interconnect model that accepts critical msi writes
`default_nettype none
module msi_sink (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        msi_valid_i,
  input  wire logic [55:0] msi_addr_i,
  input  wire logic [31:0] msi_data_i,
  output var  logic [7:0]  count_o,
  output var  logic [55:0] addr_o,
  output var  logic [31:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      count_o <= 8'h0;
    end else if (msi_valid_i) begin
      count_o <= count_o + 8'h1;
      addr_o  <= msi_addr_i;
      data_o  <= msi_data_i;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// register and msi tests for the critical msi attribute and affinity block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, wr_i, rd_i, aff_subset_i, fw_configured_i, crit_event_i;
  logic msi_valid_o, msi_ns_o;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o, msi_data_o, s_data;
  logic [1:0]  acc_space_i, aff_subset_level_i, msi_share_domain_o;
  logic [3:0]  msi_memory_type_o;
  logic [7:0]  s_count;
  logic [55:0] msi_addr_o, s_addr;
  logic [63:0] pe_id;
  int          err_count, samples_checked;
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  critical_msi_attr_and_affinity DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .acc_space_i(acc_space_i), .rdata_o(rdata_o),
    .pe_affinity_identifier_i(pe_id), .aff_subset_i(aff_subset_i),
    .aff_subset_level_i(aff_subset_level_i), .fw_configured_i(fw_configured_i),
    .crit_event_i(crit_event_i), .msi_valid_o(msi_valid_o), .msi_addr_o(msi_addr_o),
    .msi_data_o(msi_data_o), .msi_ns_o(msi_ns_o), .msi_share_domain_o(msi_share_domain_o),
    .msi_memory_type_o(msi_memory_type_o));
  msi_sink u_sink (.clock_i(clock_i), .rst_n_i(rst_n_i), .msi_valid_i(msi_valid_o),
    .msi_addr_i(msi_addr_o), .msi_data_i(msi_data_o), .count_o(s_count), .addr_o(s_addr),
    .data_o(s_data));
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    acc_space_i <= s;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // event held for n cycles, returns once the sink has taken the writes
  task automatic fire(input int n);
    @(posedge clock_i);
    crit_event_i <= 1'b1;
    repeat (n) @(posedge clock_i);
    crit_event_i <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  initial begin
    #100000;
    err_count++;
    test_done;
  end
  initial begin
    {rst_n_i, wr_i, rd_i, crit_event_i, aff_subset_i, fw_configured_i} = 6'h0;
    {addr_i, wdata_i, acc_space_i, aff_subset_level_i} = 48'h0;
    pe_id = 64'h00000012_00563478;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(12'heac, 32'h0);
    fire(1);
    chk(s_count, 8'h0);
    wr(12'hea0, 32'h12345673, 2'h0);
    wr(12'hea4, 32'h00abcdef, 2'h0);
    wr(12'hea8, 32'hdeadbeef, 2'h0);
    wr(12'heac, 32'hffffff8b, 2'h0);
    rd(12'heac, 32'h8b);
    fire(1);
    chk(s_addr, 56'habcdef12345670);
    chk(s_data, 32'hdeadbeef);
    chk({msi_ns_o, msi_share_domain_o, msi_memory_type_o}, 7'h0b);
    wr(12'heac, 32'hc0, 2'h1);
    wr(12'hea8, 32'h0, 2'h2);
    rd(12'heac, 32'h8b);
    rd(12'hea8, 32'hdeadbeef);
    wr(12'heac, 32'hc5, 2'h0);
    fire(2);
    chk(s_count, 8'h3);
    chk({msi_ns_o, msi_share_domain_o}, 3'h6);
    wr(12'heac, 32'h83, 2'h1);
    rd(12'heac, 32'hc3);
    for (int c = 0; c < 16; c++) if (c != 4 && c != 8 && c != 12) begin
      wr(12'heac, {24'h0, 4'hb, c[3:0]}, 2'h0);
      fire(1);
      chk({msi_share_domain_o, msi_memory_type_o}, {(c < 4 || c == 5) ? 2'h2 : 2'h3, c[3:0]});
    end
    rd(12'hfa8, 32'h0);
    wr(12'hf00, 32'h1, 2'h0);
    fw_configured_i <= 1'b1;
    wr(12'hfa8, 32'hffffffff, 2'h0);
    rd(12'hfa8, 32'h80563478);
    rd(12'hfac, 32'h12);
    aff_subset_i <= 1'b1;
    aff_subset_level_i <= 2'h1;
    rd(12'hfa8, 32'h00563400);
    rd(12'h100, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
